/* File: src/mp_pin_config_aux_adc_power_ctrl.sv */
/*
 * Register block that assigns each of twelve multipurpose pins a function,
 * filters the four auxiliary converter channels and drives power-down and
 * DAC setup controls.
 * Assumes the converter delivers four 8-bit samples with a one-cycle
 * sample pulse per audio sample, and that the serial port logic supplies
 * the data and drive enables for pins in serial mode.
 * Pad inputs are asynchronous and pass two flip-flops before any use.
 * The register port never stalls: writes land at the strobe edge and
 * read data stand only in the cycle after the read strobe.
 * Every output comes from a flip-flop, so derived controls follow a
 * register write by one clock.
 * The analog converters and serial port timing live outside this block.
 */
// Summary of operation
// [RL1] Two 24-bit configuration registers hold twelve 4-bit pin function fields.
// [RL2] Low register holds pins 0-5, high register 6-11, lowest pin in bits 3:0.
// [RL3] Field top bit inverts the value read from or driven onto the pin.
// [RL4] Pull-up is on whenever a pin is a GPIO or serial digital input.
// [RL5] Codes 0000-0011: debounced input, plain input, push-pull output, open-collector output.
// [RL6] Code 0100 connects the pin to the serial data port.
// [RL7] Codes 1000-1011 are the inverted forms of codes 0000-0011.
// [RL8] Software avoids reserved codes; they act as undriven inputs without pull-up.
// [RL9] Bits 9:8 select 4-bit or 5-bit hysteresis, full bypass, or filter bypass.
// [RL10] Power register bits 7,6,5,3:0 power down ADCs, buffer, reference, DAC0-3.
// [RL11] Auxiliary converter runs only while enable register bit 15 is set.
// [RL12] Software writes 01 into the DAC setup field to initialize the DACs.
// [RL13] Four auxiliary channels of 8-bit samples, each taken once per sample period.
// [RL14] Pins 9,2,3,8 feed auxiliary channels 0-3; no other pin reaches them.
// [RL15] Code 1111 connects a mapped pin to its auxiliary channel.
// [RL16] Low-pass filtering applies by default while the converter is enabled.
// [RL17] Each result reads as 16 bits: 12 data bits, low bits zero.
// [RL18] Override bit stops result storing and lets software write result registers.
// [RL19] Debounced inputs pass a new level only after a fixed count of stable samples.
// [RL20] Both the control port and the core read inputs and set output levels.
`timescale 1ns/1ps

module mp_pin_config_aux_adc_power_ctrl
	import pin_cfg_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	input  wire logic [ADDR_W-1:0]     reg_addr,
	input  wire logic [DATA_W-1:0]     reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [DATA_W-1:0]     reg_rdata,
	input  wire logic                  core_gpio_wr,
	input  wire logic [NUM_PINS-1:0]   core_gpio_wdata,
	output logic      [NUM_PINS-1:0]   gpio_level,
	input  wire logic [NUM_PINS-1:0]   pin_in,
	output logic      [NUM_PINS-1:0]   pin_out,
	output logic      [NUM_PINS-1:0]   pin_oe,
	output logic      [NUM_PINS-1:0]   pin_pullup_en,
	input  wire logic [NUM_PINS-1:0]   serial_out_data,
	input  wire logic [NUM_PINS-1:0]   serial_drive_en,
	output logic      [NUM_PINS-1:0]   serial_in_data,
	input  wire logic                  aux_sample_pulse,
	input  wire logic [NUM_AUX*8-1:0]  aux_raw_sample,
	output logic                       aux_conv_on,
	output logic      [NUM_AUX-1:0]    aux_channel_connect,
	output logic                       aux_lpf_active,
	output power_ctrl_t                power_ctrl,
	output logic                       osc_off,
	output logic      [1:0]            dac_init_field
);

	// pin index that feeds each auxiliary channel
	// the map is fixed in silicon; a 1111 code on any other pin
	// connects nothing, so a stray code cannot load the converter
	// mux with a pin that is also driven as a digital output
	localparam int AUX_PIN [NUM_AUX] = '{9, 2, 3, 8};

	// decode one 4-bit function field
	// the top bit inverts codes 0000-0011; the low three bits pick those functions, while 0100 and 1111 match all four bits
	// reserved codes clear every flag, so the pad is neither driven
	// nor pulled up; gpio_level reads zero and the input level register shows the pad
	// code 1111 is the converter input and ignores the inversion bit
	function automatic pin_mode_t decode_pin(input logic [3:0] f);
		pin_mode_t m;
		m        = '0;
		m.invert = f[INV_BIT] && (f != CODE_AUX); // see [RL3]
		case ({1'b0, f[2:0]})
			CODE_IN_DEB: m.gpio_in = 1'b1;
			CODE_IN_RAW: m.gpio_in = 1'b1;
			CODE_OUT_PP: m.gpio_out = 1'b1;
			CODE_OUT_OC: m.open_coll = 1'b1;
			default: m.gpio_in = 1'b0;
		endcase
		m.debounced = (f[2:0] == CODE_IN_DEB[2:0]); // see [RL5] see [RL7]
		if (f[2]) begin
			m = '0; // unused codes stay undriven, see [RL8]
		end
		if (f == CODE_SERIAL) begin
			m.serial = 1'b1; // see [RL6]
		end
		if (f == CODE_AUX) begin
			m.aux = 1'b1; // see [RL15]
		end
		return m;
	endfunction

	// distance between two 12-bit levels
	// used by both hysteresis modes and the raw hysteresis mode
	function automatic logic [11:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
		return (a > b) ? a - b : b - a;
	endfunction

	// software visible registers, reserved bits held at zero by masks
	// so that read back shows only what the hardware really keeps
	logic [DATA_W-1:0]     pin_cfg_lo_q;
	logic [DATA_W-1:0]     pin_cfg_hi_q;
	logic [15:0]           aux_pwr_q;
	logic [15:0]           aux_en_q;
	logic [15:0]           osc_pd_q;
	logic [15:0]           dac_setup_q;
	logic                  override_q;
	logic [NUM_PINS-1:0]   gpio_out_q;
	logic [NUM_PINS-1:0]   sync1_q;
	logic [NUM_PINS-1:0]   sync2_q;
	logic [NUM_PINS-1:0]   stable_q;
	logic [DEB_CNT_W-1:0]  deb_cnt_q [NUM_PINS];
	logic [11:0]           lpf_q     [NUM_AUX];
	logic [AUX_RES_W-1:0]  aux_res_q [NUM_AUX];
	logic [DATA_W-1:0]     rdata_d;
	pin_mode_t             mode      [NUM_PINS];
	logic [NUM_PINS-1:0]   in_value;
	logic [1:0]            fil_sel;

	// split both configuration registers into per-pin fields
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (i < PINS_PER_REG) begin
				mode[i] = decode_pin(pin_cfg_lo_q[i*FIELD_W +: FIELD_W]); // see [RL1] see [RL2]
			end else begin
				mode[i] = decode_pin(pin_cfg_hi_q[(i-PINS_PER_REG)*FIELD_W +: FIELD_W]); // see [RL2]
			end
		end
	end

	assign fil_sel = aux_pwr_q[FIL_LSB +: 2];

	// control register writes
	// reserved bits are masked on the way in rather than on the read
	// path, so the stored word and the derived controls always agree
	// unmapped addresses fall through and are ignored
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_cfg_lo_q <= RST_PIN_CFG;
			pin_cfg_hi_q <= RST_PIN_CFG;
			aux_pwr_q    <= RST_CTRL16;
			aux_en_q     <= RST_CTRL16;
			osc_pd_q     <= RST_CTRL16;
			dac_setup_q  <= RST_CTRL16;
			override_q   <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_PIN_LO:    pin_cfg_lo_q <= reg_wdata; // see [RL1]
				ADDR_PIN_HI:    pin_cfg_hi_q <= reg_wdata;
				ADDR_AUX_PWR:   aux_pwr_q    <= reg_wdata[15:0] & MASK_AUX_PWR; // see [RL9] see [RL10]
				ADDR_AUX_EN:    aux_en_q     <= reg_wdata[15:0] & MASK_AUX_EN; // see [RL11]
				ADDR_OSC_PD:    osc_pd_q     <= reg_wdata[15:0] & MASK_OSC_PD;
				ADDR_DAC_SETUP: dac_setup_q  <= reg_wdata[15:0] & MASK_DAC_SETUP;
				ADDR_CORE_CTRL: override_q   <= reg_wdata[OVERRIDE_BIT];
				default: ;
			endcase
		end
	end

	// gpio output levels, the core write lands after the port write in the same cycle
	// the core owns the pins at run time, so on a collision its
	// value wins and the port write is lost
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			gpio_out_q <= '0;
		end else if (core_gpio_wr) begin
			gpio_out_q <= core_gpio_wdata; // see [RL20]
		end else if (reg_wr && reg_addr == ADDR_GPIO_OUT) begin
			gpio_out_q <= reg_wdata[NUM_PINS-1:0]; // see [RL20]
		end
	end

	// two-stage synchroniser on the pins
	// only the second stage is read anywhere else, which keeps a
	// metastable first stage from reaching the decode logic
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// debounce: a changed level must hold for a fixed count of sample pulses
	// any return to the old level restarts the count, so a bouncing
	// contact never passes; the sample pulse is the debounce tick
	// and no separate divider is needed
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stable_q <= '0;
			for (int i = 0; i < NUM_PINS; i++) begin
				deb_cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (sync2_q[i] == stable_q[i]) begin
					deb_cnt_q[i] <= '0;
				end else if (aux_sample_pulse) begin
					if (deb_cnt_q[i] == DEB_LAST) begin
						stable_q[i]  <= sync2_q[i]; // see [RL19]
						deb_cnt_q[i] <= '0;
					end else begin
						deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
					end
				end
			end
		end
	end

	// logical input value of each pin after debounce choice and inversion
	// this is also what the input level register shows to software
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			in_value[i] = (mode[i].debounced ? stable_q[i] : sync2_q[i]) ^ mode[i].invert; // see [RL3] see [RL5]
		end
	end

	// pad drivers, pull-ups and readback levels
	// open-collector pins never drive high: the enable pulls the pad
	// low and an outside resistor gives the high level
	// a serial pin is an input with pull-up whenever the port lets go
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_out        <= '0;
			pin_oe         <= '0;
			pin_pullup_en  <= '0;
			serial_in_data <= '0;
			gpio_level     <= '0;
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				pin_out[i]        <= 1'b0;
				pin_oe[i]         <= 1'b0;
				pin_pullup_en[i]  <= 1'b0;
				serial_in_data[i] <= 1'b0;
				gpio_level[i]     <= 1'b0;
				if (mode[i].gpio_in) begin
					pin_pullup_en[i] <= 1'b1; // see [RL4]
					gpio_level[i]    <= in_value[i]; // see [RL20]
				end else if (mode[i].gpio_out) begin
					pin_out[i]    <= gpio_out_q[i] ^ mode[i].invert; // see [RL3] see [RL5]
					pin_oe[i]     <= 1'b1;
					gpio_level[i] <= gpio_out_q[i];
				end else if (mode[i].open_coll) begin
					pin_oe[i]     <= !(gpio_out_q[i] ^ mode[i].invert); // pull low only, see [RL5] see [RL7]
					gpio_level[i] <= gpio_out_q[i];
				end else if (mode[i].serial) begin
					if (serial_drive_en[i]) begin
						pin_out[i] <= serial_out_data[i]; // see [RL6]
						pin_oe[i]  <= 1'b1;
					end else begin
						pin_pullup_en[i]  <= 1'b1; // see [RL4]
						serial_in_data[i] <= sync2_q[i];
					end
				end
			end
		end
	end

	// converter switch, channel connections and power-down outputs
	// the dac bits sit in reverse order in the register: bit 3 is dac0
	// so the struct field is indexed by dac number instead
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			aux_conv_on         <= 1'b0;
			aux_channel_connect <= '0;
			aux_lpf_active      <= 1'b0;
			power_ctrl          <= '0;
			osc_off             <= 1'b0;
			dac_init_field      <= 2'h0;
		end else begin
			aux_conv_on    <= aux_en_q[AUX_CONV_ON_BIT]; // see [RL11]
			aux_lpf_active <= aux_en_q[AUX_CONV_ON_BIT] && !fil_sel[1]; // see [RL16]
			for (int c = 0; c < NUM_AUX; c++) begin
				aux_channel_connect[c] <= aux_en_q[AUX_CONV_ON_BIT] && mode[AUX_PIN[c]].aux; // see [RL14] see [RL15]
			end
			power_ctrl.audio_adc_powerdown  <= aux_pwr_q[AUDIO_ADC_POWERDOWN_BIT]; // see [RL10]
			power_ctrl.ref_buffer_powerdown <= aux_pwr_q[REF_BUFFER_POWERDOWN_BIT];
			power_ctrl.vref_powerdown       <= aux_pwr_q[VREF_POWERDOWN_BIT];
			power_ctrl.dac_powerdown        <= {aux_pwr_q[0], aux_pwr_q[1], aux_pwr_q[2], aux_pwr_q[3]};
			osc_off        <= osc_pd_q[OPD_BIT];
			dac_init_field <= dac_setup_q[1:0]; // see [RL12]
		end
	end

	// per-channel filtering and result storage, once per sample pulse
	// the 8-bit sample is widened to a 12-bit level so the filter has
	// room for fractional steps; hysteresis compares against the held
	// result so slow drift still moves it once a full step accrues
	// while the override bit is set, samples are dropped entirely
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int c = 0; c < NUM_AUX; c++) begin
				lpf_q[c]     <= '0;
				aux_res_q[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NUM_AUX; c++) begin
				logic [11:0] raw12;
				logic [11:0] level;
				logic [11:0] held;
				raw12 = {aux_raw_sample[c*8 +: 8], 4'h0}; // see [RL13]
				level = lpf_q[c] - (lpf_q[c] >> LPF_SHIFT) + (raw12 >> LPF_SHIFT);
				held  = aux_res_q[c][15:4];
				if (override_q) begin
					if (reg_wr && reg_addr == ADDR_AUX_RES0 + 16'(c)) begin
						aux_res_q[c] <= {reg_wdata[15:4], 4'h0}; // see [RL18]
					end
				end else if (aux_sample_pulse && aux_en_q[AUX_CONV_ON_BIT] && mode[AUX_PIN[c]].aux) begin
					lpf_q[c] <= level; // see [RL16]
					case (fil_sel)
						FIL_HYST4: begin
							if (abs_diff(level, held) >= HYST4_STEP) begin
								aux_res_q[c] <= {level, 4'h0}; // see [RL9] see [RL17]
							end
						end
						FIL_HYST5: begin
							if (abs_diff(level, held) >= HYST5_STEP) begin
								aux_res_q[c] <= {level, 4'h0}; // see [RL9]
							end
						end
						FIL_BYPASS: aux_res_q[c] <= {raw12, 4'h0}; // see [RL9]
						FIL_NO_LPF: begin
							if (abs_diff(raw12, held) >= HYST4_STEP) begin
								aux_res_q[c] <= {raw12, 4'h0}; // see [RL9]
							end
						end
						default: ;
					endcase
				end
			end
		end
	end

	// read multiplexer, unmapped addresses read zero
	// 16-bit registers sit in the low bits with the upper byte zero
	always_comb begin
		rdata_d = '0;
		case (reg_addr)
			ADDR_PIN_LO:    rdata_d = pin_cfg_lo_q;
			ADDR_PIN_HI:    rdata_d = pin_cfg_hi_q;
			ADDR_AUX_PWR:   rdata_d = {8'h00, aux_pwr_q};
			ADDR_AUX_EN:    rdata_d = {8'h00, aux_en_q};
			ADDR_OSC_PD:    rdata_d = {8'h00, osc_pd_q};
			ADDR_DAC_SETUP: rdata_d = {8'h00, dac_setup_q};
			ADDR_CORE_CTRL: rdata_d = {23'h000000, override_q};
			ADDR_GPIO_OUT:  rdata_d = {12'h000, gpio_out_q};
			ADDR_GPIO_IN:   rdata_d = {12'h000, in_value}; // see [RL20]
			default: begin
				for (int c = 0; c < NUM_AUX; c++) begin
					if (reg_addr == ADDR_AUX_RES0 + 16'(c)) begin
						rdata_d = {8'h00, aux_res_q[c]}; // see [RL17]
					end
				end
			end
		endcase
	end

	// read data stands for the one cycle after the read strobe
	// clearing it otherwise keeps stale data off a shared read bus
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule

/* File: src/pin_cfg_pkg.sv */
/*
 * Shared constants and types for the multipurpose pin, auxiliary converter
 * and power-down control block.
 * Assumes a 16-bit register address space reached over a plain strobe port
 * with 24-bit data; registers narrower than 24 bits sit in the low bits.
 */
package pin_cfg_pkg;

	localparam int          NUM_PINS       = 12;
	localparam int          PINS_PER_REG   = 6;
	localparam int          FIELD_W        = 4;
	localparam int          NUM_AUX        = 4;
	localparam int          ADDR_W         = 16;
	localparam int          DATA_W         = 24;
	localparam int          AUX_LEVEL_W    = 12;
	localparam int          AUX_RES_W      = 16;

	// register addresses
	localparam logic [15:0] ADDR_PIN_LO    = 16'h0820;
	localparam logic [15:0] ADDR_PIN_HI    = 16'h0821;
	localparam logic [15:0] ADDR_AUX_PWR   = 16'h0822;
	localparam logic [15:0] ADDR_AUX_EN    = 16'h0824;
	localparam logic [15:0] ADDR_OSC_PD    = 16'h0826;
	localparam logic [15:0] ADDR_DAC_SETUP = 16'h0827;
	localparam logic [15:0] ADDR_AUX_RES0  = 16'h0828; // four results at 0x0828..0x082b
	localparam logic [15:0] ADDR_CORE_CTRL = 16'h082c;
	localparam logic [15:0] ADDR_GPIO_OUT  = 16'h082d;
	localparam logic [15:0] ADDR_GPIO_IN   = 16'h082e;

	// reset values
	localparam logic [23:0] RST_PIN_CFG    = 24'h000000;
	localparam logic [15:0] RST_CTRL16     = 16'h0000;

	// field positions
	localparam int          FIL_LSB        = 8;
	localparam int          AUDIO_ADC_POWERDOWN_BIT       = 7;
	localparam int          REF_BUFFER_POWERDOWN_BIT       = 6;
	localparam int          VREF_POWERDOWN_BIT       = 5;
	localparam int          AUX_CONV_ON_BIT       = 15;
	localparam int          OPD_BIT        = 2;
	localparam int          OVERRIDE_BIT   = 0;
	localparam int          INV_BIT        = 3;

	// writable bit masks (reserved bits hold zero)
	localparam logic [15:0] MASK_AUX_PWR   = 16'h03ef;
	localparam logic [15:0] MASK_AUX_EN    = 16'h8000;
	localparam logic [15:0] MASK_OSC_PD    = 16'h0004;
	localparam logic [15:0] MASK_DAC_SETUP = 16'h0003;

	// pin function codes, low three bits after the inversion bit is split off for the first four; serial and converter codes use all four bits
	localparam logic [3:0]  CODE_IN_DEB    = 4'h0;
	localparam logic [3:0]  CODE_IN_RAW    = 4'h1;
	localparam logic [3:0]  CODE_OUT_PP    = 4'h2;
	localparam logic [3:0]  CODE_OUT_OC    = 4'h3;
	localparam logic [3:0]  CODE_SERIAL    = 4'h4;
	localparam logic [3:0]  CODE_AUX       = 4'hf;

	// filter selection codes
	localparam logic [1:0]  FIL_HYST4      = 2'h0;
	localparam logic [1:0]  FIL_HYST5      = 2'h1;
	localparam logic [1:0]  FIL_BYPASS     = 2'h2;
	localparam logic [1:0]  FIL_NO_LPF     = 2'h3;

	// filter and debounce figures
	localparam logic [11:0] HYST4_STEP     = 12'h010;
	localparam logic [11:0] HYST5_STEP     = 12'h020;
	localparam int          LPF_SHIFT      = 3;
	localparam int          DEBOUNCE_SAMPLES = 8;
	localparam int          DEB_CNT_W      = 4;
	localparam logic [3:0]  DEB_LAST       = 4'(DEBOUNCE_SAMPLES - 1);

	// decoded function of one pin
	typedef struct packed {
		logic gpio_in;
		logic debounced;
		logic gpio_out;
		logic open_coll;
		logic serial;
		logic aux;
		logic invert;
	} pin_mode_t;

	// power-down controls
	typedef struct packed {
		logic       audio_adc_powerdown;
		logic       ref_buffer_powerdown;
		logic       vref_powerdown;
		logic [3:0] dac_powerdown;
	} power_ctrl_t;

endpackage

/* File: tb/mp_pin_cfg_props.sv */
/*
 * Concurrent checks on the ports of the pin, converter and power control block.
 * Assumes one clock domain and the register map of pin_cfg_pkg.
 */
`timescale 1ns/1ps

module mp_pin_cfg_props
	import pin_cfg_pkg::*;
(
	input wire logic                 sys_clk,
	input wire logic                 arst_n,
	input wire logic [ADDR_W-1:0]    reg_addr,
	input wire logic [DATA_W-1:0]    reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [DATA_W-1:0]    reg_rdata,
	input wire logic [NUM_PINS-1:0]  pin_oe,
	input wire logic [NUM_PINS-1:0]  pin_pullup_en,
	input wire logic                 aux_conv_on,
	input wire logic [NUM_AUX-1:0]   aux_channel_connect,
	input wire logic                 aux_lpf_active,
	input wire power_ctrl_t          power_ctrl,
	input wire logic                 osc_off,
	input wire logic [1:0]           dac_init_field
);
	logic [DATA_W-1:0] wd1_q;
	logic [DATA_W-1:0] wd2_q;

	// write data two edges back, when the derived outputs show it
	always_ff @(posedge sys_clk) begin
		wd1_q <= reg_wdata;
		wd2_q <= wd1_q;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// one write strobe to a given address
	sequence wr_s(logic [15:0] a);
		reg_wr && reg_addr == a;
	endsequence

	aux_on_a: assert property (wr_s(ADDR_AUX_EN) |=> ##1 aux_conv_on == $past(reg_wdata[15], 2))
		else $error("aux enable output wrong");
	power_dn_a: assert property (wr_s(ADDR_AUX_PWR) |=> ##1
		power_ctrl == {wd2_q[7:5], wd2_q[0], wd2_q[1], wd2_q[2], wd2_q[3]})
		else $error("power-down outputs wrong");
	osc_off_a: assert property (wr_s(ADDR_OSC_PD) |=> ##1 osc_off == wd2_q[2])
		else $error("oscillator off output wrong");
	dac_init_a: assert property (wr_s(ADDR_DAC_SETUP) |=> ##1 dac_init_field == wd2_q[1:0])
		else $error("dac setup field wrong");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data outside read cycle");
	lpf_gate_a: assert property (aux_lpf_active |-> aux_conv_on)
		else $error("filter active while converter off");
	aux_gate_a: assert property (|aux_channel_connect |-> aux_conv_on)
		else $error("channel connected while converter off");
	pull_drive_a: assert property ((pin_oe & pin_pullup_en) == '0)
		else $error("pull-up on a driven pin");
endmodule

/* File: tb/mp_pin_config_aux_adc_power_ctrl_tb.sv */
/*
 * Self-checking bench for the pin, converter and power control block.
 * Assumes the register port and pin timing of the hand-over contract.
 */
`timescale 1ns/1ps

module mp_pin_config_aux_adc_power_ctrl_tb
	import pin_cfg_pkg::*;
;
	logic        sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
	logic        core_gpio_wr = 0, aux_sample_pulse = 0, aux_conv_on, aux_lpf_active, osc_off;
	logic [15:0] reg_addr = '0;
	logic [23:0] reg_wdata = '0, reg_rdata;
	logic [11:0] core_gpio_wdata = '0, pin_in = '0, serial_out_data = '0, serial_drive_en = '0;
	logic [11:0] gpio_level, pin_out, pin_oe, pin_pullup_en, serial_in_data;
	logic [31:0] aux_raw_sample = '0;
	logic [3:0]  aux_channel_connect;
	logic [1:0]  dac_init_field;
	power_ctrl_t power_ctrl;
	logic [23:0] q[$];
	int          error_cnt = 0, compares = 0;
	integer      seed = 91;

	mp_pin_config_aux_adc_power_ctrl dut_u (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .core_gpio_wr, .core_gpio_wdata, .gpio_level, .pin_in, .pin_out, .pin_oe,
		.pin_pullup_en, .serial_out_data, .serial_drive_en, .serial_in_data, .aux_sample_pulse,
		.aux_raw_sample, .aux_conv_on, .aux_channel_connect, .aux_lpf_active, .power_ctrl, .osc_off,
		.dac_init_field);

	// free-running clock
	initial forever #5 sys_clk = ~sys_clk;

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic give_verdict;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [23:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	// the expected word waits in the queue for the read data cycle
	task automatic rd(input logic [15:0] a, input logic [23:0] e);
		q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic pulse;
		aux_sample_pulse <= 1'b1;
		@(posedge sys_clk);
		aux_sample_pulse <= 1'b0;
		@(posedge sys_clk);
	endtask

	// compares each read word with the oldest expected value
	always @(posedge sys_clk) begin
		if (rd_d) chk("reg_rdata", q.pop_front(), reg_rdata);
		rd_d <= reg_rd;
	end

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		logic [11:0] lv, m, oe_e, pu_e, gl_e, out_e, si_e;
		logic [23:0] v;
		logic [31:0] raw;
		logic [15:0] ra[6];
		logic [23:0] rm[6];
		ra = '{ADDR_PIN_LO, ADDR_PIN_HI, ADDR_AUX_PWR, ADDR_AUX_EN, ADDR_OSC_PD, ADDR_DAC_SETUP};
		rm = '{24'hffffff, 24'hffffff, 24'h0003ef, 24'h008000, 24'h000004, 24'h000003};
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		// reset values, masked write and read back, unmapped place
		for (int i = 0; i < 6; i++) rd(ra[i], 24'h0);
		for (int i = 0; i < 6; i++) begin
			v = 24'($random(seed));
			wr(ra[i], v);
			rd(ra[i], v & rm[i]);
		end
		wr(16'h0823, 24'hffffff);
		rd(16'h0823, 24'h0);
		// every function code on all pins at once
		for (int c = 0; c < 16; c++) begin
			lv = 12'($random(seed));
			pin_in <= 12'($random(seed));
			serial_out_data <= 12'($random(seed));
			serial_drive_en <= 12'($random(seed));
			wr(ADDR_GPIO_OUT, {12'h0, lv});
			wr(ADDR_PIN_LO, {6{4'(c)}});
			wr(ADDR_PIN_HI, {6{4'(c)}});
			repeat (10) pulse();
			@(negedge sys_clk);
			m = {12{c[3]}};
			oe_e = '0;
			pu_e = '0;
			gl_e = '0;
			out_e = '0;
			si_e = '0;
			case (c)
				0, 1, 8, 9: begin
					pu_e = '1;
					gl_e = pin_in ^ m;
				end
				2, 10: begin
					oe_e = '1;
					out_e = lv ^ m;
					gl_e = lv;
				end
				3, 11: begin
					oe_e = ~(lv ^ m);
					gl_e = lv;
				end
				4: begin
					oe_e = serial_drive_en;
					pu_e = ~serial_drive_en;
					out_e = serial_out_data & serial_drive_en;
					si_e = pin_in & ~serial_drive_en;
				end
				default: ;
			endcase
			chk("pin_oe", oe_e, pin_oe);
			chk("pin_pullup_en", pu_e, pin_pullup_en);
			chk("pin_out", out_e, pin_out & oe_e);
			chk("serial_in_data", si_e, serial_in_data);
			chk("gpio_level", gl_e, gpio_level);
			@(posedge sys_clk);
		end
		// one converter pin at a time walks the nibbles of both registers
		wr(ADDR_AUX_EN, 24'h008000);
		for (int p = 0; p < 12; p++) begin
			wr(ADDR_PIN_LO, p < 6 ? 24'hf << (4 * p) : 24'h0);
			wr(ADDR_PIN_HI, p < 6 ? 24'h0 : 24'hf << (4 * (p - 6)));
			@(negedge sys_clk);
			chk("aux_channel_connect", {p == 8, p == 3, p == 2, p == 9}, aux_channel_connect);
			@(posedge sys_clk);
		end
		// filter bypassed, one sample on all four channels
		wr(ADDR_AUX_PWR, 24'h000200);
		wr(ADDR_PIN_LO, 24'h00ff00);
		wr(ADDR_PIN_HI, 24'h00ff00);
		raw = 32'($random(seed));
		aux_raw_sample <= raw;
		pulse();
		for (int c = 0; c < 4; c++) rd(ADDR_AUX_RES0 + 16'(c), {8'h0, raw[8 * c +: 8], 8'h0});
		@(negedge sys_clk);
		chk("aux_lpf_active", 24'h0, aux_lpf_active);
		@(posedge sys_clk);
		// override: port writes land, samples are not stored
		wr(ADDR_CORE_CTRL, 24'h1);
		wr(ADDR_AUX_RES0, 24'h00abcd);
		aux_raw_sample <= ~raw;
		pulse();
		rd(ADDR_AUX_RES0, 24'h00abc0);
		rd(ADDR_AUX_RES0 + 16'h1, {8'h0, raw[15:8], 8'h0});
		wr(ADDR_CORE_CTRL, 24'h0);
		wr(ADDR_AUX_PWR, 24'h0);
		@(negedge sys_clk);
		chk("aux_lpf_active", 24'h1, aux_lpf_active);
		@(posedge sys_clk);
		wr(ADDR_AUX_EN, 24'h0);
		@(negedge sys_clk);
		chk("aux_channel_connect", 24'h0, aux_channel_connect);
		@(posedge sys_clk);
		// core and port write the output levels in the same cycle
		reg_addr <= ADDR_GPIO_OUT;
		reg_wdata <= 24'h000a5a;
		reg_wr <= 1'b1;
		core_gpio_wr <= 1'b1;
		core_gpio_wdata <= 12'h3c3;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		core_gpio_wr <= 1'b0;
		@(posedge sys_clk);
		rd(ADDR_GPIO_OUT, 24'h0003c3);
		repeat (3) @(posedge sys_clk);
		give_verdict();
	end
endmodule

bind mp_pin_config_aux_adc_power_ctrl mp_pin_cfg_props props_u (.sys_clk, .arst_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .pin_oe, .pin_pullup_en, .aux_conv_on, .aux_channel_connect,
	.aux_lpf_active, .power_ctrl, .osc_off, .dac_init_field);
